// File: common/rogf_pkg.sv
// How it works
// R01 - Twelve relay outputs each follow one bit of the twelve-bit data field as a contact closure.
// R02 - A separate gate relay and a completion flag line carry the handshake with the external timer.
// R03 - With timing mode off the card gates its data out without waiting for any answer.
// R04 - With timing mode on the card runs a gate and flag exchange and reports acceptance back.
// R05 - In timing mode the completion flag falls when the transfer ends and that edge raises an interrupt.
// R06 - With the instrument bus link chosen, a finished timing transfer raises the service request.
// R07 - Without an external timer the installer wires the gate output straight to the flag input.
// R08 - For automatic operation software first sets system and transfer enable, then writes the data.
// R09 - An all-ones data field is a valid value that closes every relay.
// R10 - After a write only relays whose data bit is set are closed.
// R11 - For timing mode software sets transfer, system and timing enable, then writes the data.
// R12 - The completion flag line is driven only while data transfer enable is on.
// R13 - After the completion interrupt software clears timing mode enable before going on.
// R14 - A data write moves its data to the relays at once, whatever transfer enable holds.
// R15 - The gate is withheld until data transfer enable is set, so preloaded cards gate out together.
// R16 - In timing mode the flag stays pending while the flag input is open and returns once it closes.
// R17 - After the flag returns the card goes idle and keeps its relays latched until the next write.
package rogf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_INTS = 8'h0c;
  localparam logic [7:0] ADDR_INTM = 8'h10;
  localparam int CTRL_SYE = 0;
  localparam int CTRL_DTE = 1;
  localparam int CTRL_TME = 2;
  localparam int CTRL_BUS = 3;
  localparam int DATA_W = 12;
  localparam logic [DATA_W-1:0] RELAY_RST = 12'h000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_GATE = 3'b100
  } rogf_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rogf_apb_req_t;

  typedef struct packed {
    rogf_state_t state;
    logic system_enable_bit;
    logic data_transfer_enable_bit;
    logic timing_mode_enable_bit;
    logic bus_sel;
    logic [DATA_W-1:0] relay;
    logic gate;
    logic completion_timing_flag;
    logic ctf_oe;
    logic srq;
    logic int_sts;
    logic int_msk;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rogf_regs_t;
endpackage : rogf_pkg

// File: core/rogf_top.sv
`timescale 1ns/1ps
module rogf_top (
  input wire logic mclk, // 100 MHz clock
  input wire logic resetn, // synchronous reset, active low
  input wire rogf_pkg::rogf_apb_req_t apb_req, // apb request group
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic [31:0] prdata, // apb read data
  input wire logic flag_in, // external flag contact, high when closed
  output logic [rogf_pkg::DATA_W-1:0] relay_o, // relay coils, high closes contact
  output logic gate_o, // gate relay
  output logic ctf_o, // completion flag level, falls at completion
  output logic ctf_oe, // completion flag line drive enable
  output logic srq_o, // service request on the instrument bus link
  output logic irq_o // level interrupt
);
  rogf_pkg::rogf_regs_t st_ff;
  rogf_pkg::rogf_regs_t nxt_st;
  logic access;
  logic wr;
  logic rd;
  logic data_wr;
  logic done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // true for every offset that holds a register
  function automatic logic mapped_addr(input logic [7:0] a);
    mapped_addr = hit(a, rogf_pkg::ADDR_CTRL) |
                  hit(a, rogf_pkg::ADDR_DATA) |
                  hit(a, rogf_pkg::ADDR_STAT) |
                  hit(a, rogf_pkg::ADDR_INTS) |
                  hit(a, rogf_pkg::ADDR_INTM);
  endfunction : mapped_addr

  // apb access phase decode
  assign access = apb_req.psel & apb_req.penable & st_ff.pready;
  assign wr = access & apb_req.pwrite;
  assign rd = access & ~apb_req.pwrite;
  assign data_wr = wr & hit(apb_req.paddr, rogf_pkg::ADDR_DATA);
  // completion: flag contact closed while gating in timing mode
  assign done = (st_ff.state == rogf_pkg::ST_GATE) & st_ff.timing_mode_enable_bit & flag_in; // [R16]

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = apb_req.psel & apb_req.penable & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    if (nxt_st.pready) begin
      nxt_st.pslverr = ~mapped_addr(apb_req.paddr);
    end
    // control writes
    if (wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL)) begin
      nxt_st.system_enable_bit = apb_req.pwdata[rogf_pkg::CTRL_SYE];
      nxt_st.data_transfer_enable_bit = apb_req.pwdata[rogf_pkg::CTRL_DTE];
      nxt_st.timing_mode_enable_bit = apb_req.pwdata[rogf_pkg::CTRL_TME];
      nxt_st.bus_sel = apb_req.pwdata[rogf_pkg::CTRL_BUS];
    end
    if (wr && hit(apb_req.paddr, rogf_pkg::ADDR_INTM)) begin
      nxt_st.int_msk = apb_req.pwdata[0];
    end
    // write one clears, a new completion in the same cycle wins
    if (wr && hit(apb_req.paddr, rogf_pkg::ADDR_INTS) && apb_req.pwdata[0]) begin
      nxt_st.int_sts = 1'b0;
    end
    // service request drops once software turns timing mode off
    if (st_ff.timing_mode_enable_bit && !nxt_st.timing_mode_enable_bit) begin
      nxt_st.srq = 1'b0; // [R13]
    end
    // data word: relays follow at once, every bit pattern accepted
    if (data_wr) begin
      nxt_st.relay = apb_req.pwdata[rogf_pkg::DATA_W-1:0]; // [R01] [R09] [R10] [R14]
    end
    // gate sequencing
    case (st_ff.state)
      rogf_pkg::ST_IDLE: begin
        if (data_wr) begin
          nxt_st.state = rogf_pkg::ST_ARMED;
        end
      end
      rogf_pkg::ST_ARMED: begin
        if (st_ff.data_transfer_enable_bit && st_ff.system_enable_bit) begin
          nxt_st.state = rogf_pkg::ST_GATE; // [R15]
        end
      end
      rogf_pkg::ST_GATE: begin
        if (!st_ff.timing_mode_enable_bit) begin
          nxt_st.state = data_wr ? rogf_pkg::ST_ARMED : rogf_pkg::ST_IDLE; // [R03]
        end else if (flag_in) begin
          nxt_st.state = data_wr ? rogf_pkg::ST_ARMED : rogf_pkg::ST_IDLE; // [R04] [R17]
        end
      end
      default: begin
        nxt_st.state = rogf_pkg::ST_IDLE;
      end
    endcase
    if (done) begin
      nxt_st.int_sts = 1'b1; // [R05]
      if (st_ff.bus_sel) begin
        nxt_st.srq = 1'b1; // [R06]
      end
    end
    // gate relay and flag follow the sequencer
    nxt_st.gate = (nxt_st.state == rogf_pkg::ST_GATE); // [R02]
    nxt_st.completion_timing_flag = nxt_st.timing_mode_enable_bit & (nxt_st.state != rogf_pkg::ST_IDLE); // [R05] [R16]
    nxt_st.ctf_oe = nxt_st.data_transfer_enable_bit; // [R12]
    nxt_st.irq = nxt_st.int_sts & nxt_st.int_msk;
    // read data
    nxt_st.prdata = rogf_pkg::ZERO_WORD;
    if (nxt_st.pready && !apb_req.pwrite) begin
      if (hit(apb_req.paddr, rogf_pkg::ADDR_CTRL)) begin
        nxt_st.prdata[rogf_pkg::CTRL_SYE] = st_ff.system_enable_bit;
        nxt_st.prdata[rogf_pkg::CTRL_DTE] = st_ff.data_transfer_enable_bit;
        nxt_st.prdata[rogf_pkg::CTRL_TME] = st_ff.timing_mode_enable_bit;
        nxt_st.prdata[rogf_pkg::CTRL_BUS] = st_ff.bus_sel;
      end else if (hit(apb_req.paddr, rogf_pkg::ADDR_DATA)) begin
        nxt_st.prdata[rogf_pkg::DATA_W-1:0] = st_ff.relay;
      end else if (hit(apb_req.paddr, rogf_pkg::ADDR_STAT)) begin
        nxt_st.prdata[2:0] = st_ff.state;
        nxt_st.prdata[3] = st_ff.gate;
        nxt_st.prdata[4] = st_ff.completion_timing_flag;
        nxt_st.prdata[5] = flag_in;
        nxt_st.prdata[6] = st_ff.srq;
      end else if (hit(apb_req.paddr, rogf_pkg::ADDR_INTS)) begin
        nxt_st.prdata[0] = st_ff.int_sts;
      end else if (hit(apb_req.paddr, rogf_pkg::ADDR_INTM)) begin
        nxt_st.prdata[0] = st_ff.int_msk;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_ff <= '{state: rogf_pkg::ST_IDLE, relay: rogf_pkg::RELAY_RST,
                 prdata: rogf_pkg::ZERO_WORD, default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign prdata = st_ff.prdata;
  assign relay_o = st_ff.relay;
  assign gate_o = st_ff.gate;
  assign ctf_o = st_ff.completion_timing_flag;
  assign ctf_oe = st_ff.ctf_oe;
  assign srq_o = st_ff.srq;
  assign irq_o = st_ff.irq;

  // checks
  sequence s_pending;
    gate_o && st_ff.timing_mode_enable_bit && !flag_in;
  endsequence
  sequence s_closed;
    gate_o && st_ff.timing_mode_enable_bit && flag_in && !data_wr;
  endsequence
  sequence s_returned;
    !gate_o && !ctf_o && st_ff.int_sts;
  endsequence
  sequence s_data_idle;
    data_wr && st_ff.state == rogf_pkg::ST_IDLE;
  endsequence
  sequence s_armed;
    st_ff.state == rogf_pkg::ST_ARMED;
  endsequence
  sequence s_armed_go;
    st_ff.state == rogf_pkg::ST_ARMED && st_ff.data_transfer_enable_bit && st_ff.system_enable_bit;
  endsequence
  sequence s_gate_up;
    gate_o && st_ff.state == rogf_pkg::ST_GATE;
  endsequence

  chk_relay_follow: assert property (@(posedge mclk) disable iff (!resetn) // [R10] [R14]
    data_wr |=> relay_o == $past(apb_req.pwdata[11:0]))
    else $error("relays do not follow data word");
  chk_gate_waits_dte: assert property (@(posedge mclk) disable iff (!resetn) // [R15]
    $rose(gate_o) |-> $past(st_ff.data_transfer_enable_bit) && $past(st_ff.system_enable_bit))
    else $error("gate raised without transfer enable");
  chk_flag_pending: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
    s_pending |=> gate_o && ctf_o)
    else $error("flag returned while flag input open");
  chk_flag_return: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    s_closed |=> s_returned)
    else $error("flag not returned after flag input closed");
  chk_auto_no_wait: assert property (@(posedge mclk) disable iff (!resetn) // [R03]
    (gate_o && !st_ff.timing_mode_enable_bit && !data_wr) |=> !gate_o)
    else $error("automatic mode gate waited");
  chk_timing_start: assert property (@(posedge mclk) disable iff (!resetn) // [R04]
    (data_wr && st_ff.timing_mode_enable_bit && st_ff.data_transfer_enable_bit && st_ff.system_enable_bit &&
     st_ff.state == rogf_pkg::ST_IDLE) |=> ctf_o ##1 gate_o)
    else $error("timing sequence did not start");
  chk_srq_set: assert property (@(posedge mclk) disable iff (!resetn) // [R06]
    (done && st_ff.bus_sel) |=> srq_o)
    else $error("service request not raised");
  chk_ctf_drive: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
    (wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL)) |=>
      ctf_oe == $past(apb_req.pwdata[rogf_pkg::CTRL_DTE]))
    else $error("flag line driven without transfer enable");
  chk_irq_level: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    irq_o == (st_ff.int_sts && st_ff.int_msk))
    else $error("interrupt output wrong");
  chk_idle_latch: assert property (@(posedge mclk) disable iff (!resetn) // [R17]
    ($fell(gate_o) && !$past(data_wr)) |-> relay_o == $past(relay_o))
    else $error("relays changed on return to idle");
  chk_apb_answer: assert property (@(posedge mclk) disable iff (!resetn)
    (apb_req.psel && apb_req.penable && !pready) |=> pready)
    else $error("apb answer late");

  // reset leaves every output low
  chk_reset_clears: assert property (@(posedge mclk)
    !resetn |=> !gate_o && !ctf_o && !srq_o && !irq_o && !pready && relay_o == rogf_pkg::RELAY_RST)
    else $error("outputs not cleared by reset");

  // register bus answer shape
  // pready stands one cycle only
  chk_pready_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  // error only comes with the answer
  chk_err_with_ready: assert property (@(posedge mclk) disable iff (!resetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  // read data is zero outside the answer
  chk_rdata_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    !pready |-> prdata == rogf_pkg::ZERO_WORD)
    else $error("read data not zero when idle");
  // unmapped offsets answer with an error
  chk_bad_addr_err: assert property (@(posedge mclk) disable iff (!resetn)
    (apb_req.psel && apb_req.penable && !pready && !mapped_addr(apb_req.paddr)) |=> pslverr)
    else $error("unmapped access without error");
  // mapped offsets answer cleanly
  chk_good_addr_ok: assert property (@(posedge mclk) disable iff (!resetn)
    (apb_req.psel && apb_req.penable && !pready && mapped_addr(apb_req.paddr)) |=> !pslverr)
    else $error("mapped access flagged as error");
  // a write answer carries no read data
  chk_write_no_data: assert property (@(posedge mclk) disable iff (!resetn)
    (pready && apb_req.pwrite) |-> prdata == rogf_pkg::ZERO_WORD)
    else $error("read data on a write answer");
  // unmapped writes touch nothing
  chk_bad_write_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (wr && !mapped_addr(apb_req.paddr)) |=> $stable(relay_o) && $stable(st_ff.timing_mode_enable_bit))
    else $error("unmapped write changed state");
  // data offset reads back the relays
  chk_read_relays: assert property (@(posedge mclk) disable iff (!resetn) // [R14]
    (rd && hit(apb_req.paddr, rogf_pkg::ADDR_DATA)) |-> prdata[rogf_pkg::DATA_W-1:0] == relay_o)
    else $error("relay read back wrong");

  // control and mask registers
  // control write loads the enable bits
  chk_ctrl_write: assert property (@(posedge mclk) disable iff (!resetn) // [R03] [R04]
    (wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL)) |=>
      st_ff.timing_mode_enable_bit == $past(apb_req.pwdata[rogf_pkg::CTRL_TME]))
    else $error("control write lost");
  // flag drive enable changes only by a control write
  chk_ctf_oe_hold: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
    !(wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL)) |=> $stable(ctf_oe))
    else $error("flag drive enable changed alone");
  // mask write loads the mask
  chk_mask_write: assert property (@(posedge mclk) disable iff (!resetn)
    (wr && hit(apb_req.paddr, rogf_pkg::ADDR_INTM)) |=> st_ff.int_msk == $past(apb_req.pwdata[0]))
    else $error("mask write lost");

  // gate sequencer
  // state code stays one-hot
  chk_state_onehot: assert property (@(posedge mclk) disable iff (!resetn)
    $onehot(st_ff.state))
    else $error("state code not one-hot");
  // gate relay closed only in the gate state
  chk_gate_state: assert property (@(posedge mclk) disable iff (!resetn) // [R02]
    gate_o == (st_ff.state == rogf_pkg::ST_GATE))
    else $error("gate relay out of step with state");
  // flag pending exactly while a timing transfer runs
  chk_ctf_level: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
    ctf_o == (st_ff.timing_mode_enable_bit && st_ff.state != rogf_pkg::ST_IDLE))
    else $error("flag level wrong");
  // pending flag needs timing mode
  chk_ctf_needs_tme: assert property (@(posedge mclk) disable iff (!resetn) // [R04]
    ctf_o |-> st_ff.timing_mode_enable_bit)
    else $error("flag pending outside timing mode");
  // a data word in idle arms the gate
  chk_arm_on_data: assert property (@(posedge mclk) disable iff (!resetn) // [R14]
    s_data_idle |=> s_armed)
    else $error("data word did not arm the gate");
  // armed without enables keeps the gate open
  chk_armed_hold: assert property (@(posedge mclk) disable iff (!resetn) // [R15]
    (st_ff.state == rogf_pkg::ST_ARMED && !(st_ff.data_transfer_enable_bit && st_ff.system_enable_bit)) |=> !gate_o)
    else $error("gate closed without enables");
  // armed with enables closes the gate next cycle
  chk_armed_go: assert property (@(posedge mclk) disable iff (!resetn) // [R15]
    s_armed_go |=> s_gate_up)
    else $error("armed gate not released");
  // gate only closes out of the armed state
  chk_gate_from_arm: assert property (@(posedge mclk) disable iff (!resetn) // [R15]
    $rose(gate_o) |-> $past(st_ff.state == rogf_pkg::ST_ARMED))
    else $error("gate closed without arming");
  // relays change only on a data word
  chk_relay_hold: assert property (@(posedge mclk) disable iff (!resetn) // [R17]
    !data_wr |=> $stable(relay_o))
    else $error("relays changed without data word");

  // completion, interrupt and service request
  // completion sets the status bit
  chk_sts_set: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    done |=> st_ff.int_sts)
    else $error("completion not recorded");
  // write one clears the status bit
  chk_sts_clear: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    (wr && hit(apb_req.paddr, rogf_pkg::ADDR_INTS) && apb_req.pwdata[0] && !done) |=>
      !st_ff.int_sts)
    else $error("status not cleared");
  // status holds without completion or clear
  chk_sts_hold: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    (!done && !(wr && hit(apb_req.paddr, rogf_pkg::ADDR_INTS))) |=> $stable(st_ff.int_sts))
    else $error("status changed alone");
  // interrupt needs a set status bit
  chk_irq_needs_sts: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    irq_o |-> st_ff.int_sts)
    else $error("interrupt without status");
  // interrupt rises only when unmasked
  chk_irq_rise: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    $rose(irq_o) |-> st_ff.int_msk)
    else $error("masked interrupt raised");
  // completion opens the gate relay
  chk_done_gate_drop: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
    done |=> !gate_o)
    else $error("gate held after completion");
  // timing mode off clears the service request
  chk_srq_clear: assert property (@(posedge mclk) disable iff (!resetn) // [R13]
    (wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL) && st_ff.timing_mode_enable_bit &&
     !apb_req.pwdata[rogf_pkg::CTRL_TME] && !done) |=> !srq_o)
    else $error("service request not cleared");
  // service request rises only on completion with the bus link
  chk_srq_bus_only: assert property (@(posedge mclk) disable iff (!resetn) // [R06]
    $rose(srq_o) |-> $past(done && st_ff.bus_sel))
    else $error("service request without bus link completion");
  // service request holds between events
  chk_srq_hold: assert property (@(posedge mclk) disable iff (!resetn) // [R06]
    (!done && !(wr && hit(apb_req.paddr, rogf_pkg::ADDR_CTRL))) |=> $stable(srq_o))
    else $error("service request changed alone");
endmodule : rogf_top

// File: bench/rogf_flag_dev.sv
`timescale 1ns/1ps
module rogf_flag_dev (
  input wire logic mclk, // clock
  input wire logic gate_in, // gate relay from the card
  input wire logic [7:0] dly, // gate cycles before the flag contact closes
  output logic flag_out // flag contact, high when closed
);
  int cnt = 0;
  // count how long the gate has been closed, restart when it opens
  always @(posedge mclk) begin
    cnt <= gate_in ? cnt + 1 : 0;
  end
  // a delay of zero acts as the gate-to-flag jumper; contact opens with the gate
  assign flag_out = gate_in && (cnt >= int'(dly));
endmodule : rogf_flag_dev

// File: bench/test_relay_output_gate_flag_card.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_relay_output_gate_flag_card;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  rogf_pkg::rogf_apb_req_t req = '0;
  logic pready, pslverr, flag_in, gate_o, ctf_o, ctf_oe, srq_o, irq_o, err;
  logic [31:0] prdata, rd;
  logic [11:0] relay_o;
  logic [7:0] dly = 8'h00;
  logic [31:0] seed = 32'hb4c7;
  int errors = 0;
  int comparisons = 0;
  int exp_relay = 0;
  int n;
  // free-running clock
  always #5 mclk = ~mclk;
  rogf_top DUT (.mclk(mclk), .resetn(resetn), .apb_req(req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .flag_in(flag_in), .relay_o(relay_o),
    .gate_o(gate_o), .ctf_o(ctf_o), .ctf_oe(ctf_oe), .srq_o(srq_o), .irq_o(irq_o));
  rogf_flag_dev partner (.mclk(mclk), .gate_in(gate_o), .dly(dly), .flag_out(flag_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // one apb transfer, held until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  // count gate cycles over a window
  task automatic gates(input int c);
    n = 0;
    repeat (c) begin
      @(posedge mclk);
      n += int'(gate_o);
    end
  endtask : gates
  task automatic print_verdict;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    apb(1'b1, rogf_pkg::ADDR_CTRL, 32'h3);
    apb(1'b1, rogf_pkg::ADDR_DATA, 32'hfff);
    exp_relay = 'hfff;
    gates(6);
    `CHK(n, 1)
    `CHK(relay_o, exp_relay[11:0])
    // random words, then random single bits
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      exp_relay = (i < 4) ? int'(seed[11:0]) : (1 << (seed[7:0] % 12));
      apb(1'b1, rogf_pkg::ADDR_DATA, 32'(exp_relay));
      gates(4);
      `CHK(relay_o, exp_relay[11:0])
      `CHK(n, 1)
    end
    // preload with transfer enable off, then gate out
    apb(1'b1, rogf_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, rogf_pkg::ADDR_DATA, 32'h0a5);
    gates(6);
    `CHK(n, 0)
    `CHK(relay_o, 12'h0a5)
    apb(1'b0, rogf_pkg::ADDR_DATA, 32'h0);
    `CHK(rd, 32'h0a5)
    apb(1'b1, rogf_pkg::ADDR_CTRL, 32'h3);
    gates(6);
    `CHK(n, 1)
    // timing mode: jumpered and masked, then slow timer unmasked on the instrument bus
    for (int i = 0; i < 2; i++) begin
      dly <= 8'(i * 6);
      apb(1'b1, rogf_pkg::ADDR_INTM, 32'(i));
      apb(1'b1, rogf_pkg::ADDR_CTRL, 32'h7 | 32'(i << 3));
      apb(1'b1, rogf_pkg::ADDR_DATA, 32'h5a5);
      `CHK(ctf_oe, 1'b1)
      n = 0;
      repeat (30) begin
        @(posedge mclk);
        n += int'(ctf_o);
        if (ctf_o === 1'b1) `CHK(irq_o, 1'b0)
      end
      `CHK(n >= i * 6, 1'b1)
      `CHK({ctf_o, gate_o}, 2'b00)
      `CHK(irq_o, 1'(i))
      `CHK(srq_o, 1'(i))
      `CHK(relay_o, 12'h5a5)
      apb(1'b0, rogf_pkg::ADDR_INTS, 32'h0);
      `CHK(rd, 32'h1)
      apb(1'b1, rogf_pkg::ADDR_INTS, 32'h1);
      `CHK(irq_o, 1'b0)
      apb(1'b1, rogf_pkg::ADDR_CTRL, 32'h3);
      `CHK(srq_o, 1'b0)
    end
    apb(1'b1, 8'h3c, 32'h0);
    `CHK(err, 1'b1)
    `CHK(relay_o, 12'h5a5)
    print_verdict;
  end
endmodule : test_relay_output_gate_flag_card
